//--- tqw_pkg.sv
package tqw_pkg;

    // Register addresses on the serial port
    localparam logic [6:0] ADDR_CFG_A = 7'h13;
    localparam logic [6:0] ADDR_CFG_B = 7'h14;
    localparam logic [6:0] ADDR_TRIG = 7'h15;
    localparam logic [6:0] ADDR_RPULSE = 7'h16;
    localparam logic [6:0] ADDR_QACFG = 7'h2d;
    localparam logic [6:0] ADDR_ANSWER = 7'h2e;
    localparam logic [6:0] ADDR_QUESTION = 7'h2f;

    // Field positions
    localparam int CFGA_MODE_LSB = 6;
    localparam int CFGA_PRE_LSB = 4;
    localparam int CFGA_ERR_LSB = 2;
    localparam int CFGA_THR_LSB = 0;
    localparam int CFGB_CODE_LSB = 5;
    localparam int CFGB_ERR_LSB = 1;
    localparam int CFGB_EN_BIT = 0;

    // Operating modes
    localparam logic [1:0] MODE_TIMEOUT = 2'h0;
    localparam logic [1:0] MODE_WINDOW = 2'h1;
    localparam logic [1:0] MODE_QA = 2'h2;

    // Failure thresholds and counter limits
    localparam logic [3:0] THR_FIRST = 4'h1;
    localparam logic [3:0] THR_FIFTH = 4'h5;
    localparam logic [3:0] THR_NINTH = 4'h9;
    localparam logic [3:0] ERR_MAX = 4'hf;
    localparam logic [3:0] Q_SUBST = 4'h1;

    // Serial frame: one command byte, one data byte
    localparam logic [4:0] CMD_BITS = 5'h08;
    localparam logic [4:0] FRAME_BITS = 5'h10;

    // Millisecond tick derived from the clock rate
    localparam int CLK_PERIOD_NS = 100;
    localparam int TICK_TIME_NS = 1000000;
    localparam int TICK_CYCLES = TICK_TIME_NS / CLK_PERIOD_NS;

    // Period in ms indexed by {period_code, period_prescale}; 0 = reserved
    localparam logic [15:0] PERIOD_MS [32] = '{
        16'd4, 16'd8, 16'd12, 16'd16,
        16'd32, 16'd64, 16'd96, 16'd128,
        16'd128, 16'd256, 16'd384, 16'd512,
        16'd256, 16'd384, 16'd512, 16'd768,
        16'd512, 16'd1024, 16'd1536, 16'd2048,
        16'd2048, 16'd4096, 16'd6144, 16'd8192,
        16'd10240, 16'd20240, 16'd0, 16'd0,
        16'd0, 16'd0, 16'd0, 16'd0};

    // Expected answers per question, bytes {resp3, resp2, resp1, resp0}
    localparam logic [31:0] ANSWERS [16] = '{
        32'hff0ff000, 32'hb040bf4f, 32'he919e616, 32'ha656a959,
        32'h75857a8a, 32'h3aca35c5, 32'h63936c9c, 32'h2cdc23d3,
        32'hd222dd2d, 32'h9d6d9262, 32'hc434cb3b, 32'h8b7b8474,
        32'h58a857a7, 32'h17e718e8, 32'h4ebe41b1, 32'h01f10efe};

endpackage

//--- tqw_watchdog.sv
// Summary of operation
// - Disabled at reset; starts on first trigger
// - Timer and limp output off in sleep
// - Failure drives limp output or interrupt low
// - Error counter up on error, down, floor zero
// - Threshold first, fifth or ninth; count readable
// - Two-bit field selects timeout, window, QA
// - Period looked up from prescale and code
// - Timing rewrite stops timer until next trigger
// - Window mode: closed half then open half
// - Trigger write restarts with closed window
// - QA period split into two half windows
// - Correct answer gives new question, restarts
// - Wrong answer keeps question, counts error
// - Next question ready one clock after answer
// - Current question readable at any time
// - Generator advances on completed good sequence
// - All-zero generator state replaced by 0001
`timescale 1ns/1ps
`default_nettype none
module tqw_watchdog
    import tqw_pkg::*;
#(
    parameter int TICK = TICK_CYCLES
)
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic sclk,
    input wire logic csn,
    input wire logic sdi,
    output logic sdo,
    output logic sdo_oe,
    input wire logic sleep_mode,
    input wire logic standby_mode,
    input wire logic standby_wd_enable,
    input wire logic limp_select,
    output logic irq_out_low,
    output logic inhibit_output
);

    typedef struct packed {
        logic [1:0] sclk_sy;
        logic [1:0] cs_sy;
        logic [1:0] sdi_sy;
        logic sclk_p;
        logic [4:0] bits;
        logic [15:0] rx;
        logic [7:0] tx;
        logic [1:0] mode;
        logic [1:0] pre;
        logic [1:0] thr;
        logic [2:0] code;
        logic en;
        logic [7:0] rpulse;
        logic [7:0] qacfg;
        logic running;
        logic [23:0] tick;
        logic [15:0] ms;
        logic [3:0] err;
        logic [3:0] question;
        logic [1:0] acnt;
        logic abad;
        logic irq;
        logic limp;
    } tqw_state_t;

    tqw_state_t q, d;
    logic [1:0] rst_sy;
    logic rst_n, rise, fall, wr_ev, rd_ev, trig_wr, ans_wr, q_rd;
    logic timing_wr, active, start, expire, in_first, match, inc, dec;
    logic good, restart;
    logic [15:0] per;
    logic [1:0] k;
    logic [6:0] waddr;
    logic [7:0] wdata;

    function automatic logic [3:0] thr_level(input logic [1:0] sel);
        case (sel)
            2'h1: thr_level = THR_FIFTH;
            2'h2: thr_level = THR_NINTH;
            default: thr_level = THR_FIRST;
        endcase
    endfunction

    function automatic logic [7:0] reg_read(input logic [6:0] a,
                                            input tqw_state_t s);
        logic [1:0] e2;
        e2 = (s.err > 4'h3) ? 2'h3 : s.err[1:0];
        case (a)
            ADDR_CFG_A: reg_read = {s.mode, s.pre, e2, s.thr};
            ADDR_CFG_B: reg_read = {s.code, s.err, s.en};
            ADDR_RPULSE: reg_read = s.rpulse;
            ADDR_QACFG: reg_read = s.qacfg;
            ADDR_QUESTION: reg_read = {1'b0, s.abad, s.acnt, s.question};
            default: reg_read = 8'h00;
        endcase
    endfunction

    // Reset release through two flops; assertion is immediate
    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
            rst_sy <= 2'b00;
        else
            rst_sy <= {rst_sy[0], 1'b1};
    end
    assign rst_n = rst_sy[1];

    always_comb
    begin
        d = q;
        wr_ev = 1'b0;
        rd_ev = 1'b0;
        trig_wr = 1'b0;
        ans_wr = 1'b0;
        timing_wr = 1'b0;
        start = 1'b0;
        match = 1'b0;
        inc = 1'b0;
        dec = 1'b0;
        good = 1'b0;
        restart = 1'b0;
        // Serial pins pass two flops before any logic looks at them
        d.sclk_sy = {q.sclk_sy[0], sclk};
        d.cs_sy = {q.cs_sy[0], ~csn};
        d.sdi_sy = {q.sdi_sy[0], sdi};
        d.sclk_p = q.sclk_sy[1];
        rise = q.sclk_sy[1] & ~q.sclk_p & q.cs_sy[1];
        fall = ~q.sclk_sy[1] & q.sclk_p & q.cs_sy[1];
        // Serial frame: bit 7 of command set means write
        if (!q.cs_sy[1])
            d.bits = 5'h00;
        else if (rise && q.bits < FRAME_BITS)
        begin
            d.rx = {q.rx[14:0], q.sdi_sy[1]};
            d.bits = q.bits + 5'h01;
            if (q.bits == CMD_BITS - 5'h01)
            begin
                d.tx = reg_read(d.rx[6:0], q);
                rd_ev = ~d.rx[7];
            end
            if (q.bits == FRAME_BITS - 5'h01)
                wr_ev = d.rx[15];
        end
        else if (fall && q.bits > CMD_BITS && q.bits < FRAME_BITS)
            d.tx = {q.tx[6:0], 1'b0};
        waddr = d.rx[14:8];
        wdata = d.rx[7:0];
        q_rd = rd_ev && (d.rx[6:0] == ADDR_QUESTION);
        // Register writes and their side effects
        if (wr_ev)
        begin
            case (waddr)
                ADDR_CFG_A:
                begin
                    d.mode = wdata[CFGA_MODE_LSB +: 2];
                    d.pre = wdata[CFGA_PRE_LSB +: 2];
                    d.thr = wdata[CFGA_THR_LSB +: 2];
                    timing_wr = q.running && (d.pre != q.pre);
                end
                ADDR_CFG_B:
                begin
                    d.code = wdata[CFGB_CODE_LSB +: 3];
                    d.en = wdata[CFGB_EN_BIT];
                    timing_wr = q.running && (d.code != q.code);
                end
                ADDR_TRIG: trig_wr = 1'b1;
                ADDR_RPULSE: d.rpulse = wdata;
                ADDR_QACFG: d.qacfg = wdata;
                ADDR_ANSWER: ans_wr = 1'b1;
                default: ;
            endcase
        end
        // Period and half-period phase
        per = PERIOD_MS[{q.code, q.pre}];
        in_first = q.ms < (per >> 1);
        expire = q.running && per != 16'h0000 && q.ms >= per;
        k = 2'h3 - q.acnt;
        match = wdata == ANSWERS[q.question][{k, 3'b000} +: 8];
        active = q.en & ~sleep_mode & (~standby_mode | standby_wd_enable);
        if (q.running)
        begin
            if (q.tick == 24'(TICK - 1))
            begin
                d.tick = 24'h000000;
                d.ms = q.ms + 16'h0001;
            end
            else
                d.tick = q.tick + 24'h000001;
        end
        if (!active || timing_wr)
        begin
            // Stopped until enabled and triggered again
            d.running = 1'b0;
            restart = 1'b1;
        end
        else
        begin
            start = !q.running &&
                (trig_wr || (q.mode == MODE_QA && (ans_wr || q_rd)));
            // Counters were cleared on stop, so a starting answer counts
            if (start)
                d.running = 1'b1;
            case (q.mode)
                MODE_TIMEOUT:
                begin
                    if (q.running && trig_wr)
                        dec = 1'b1;
                    else if (expire)
                        inc = 1'b1;
                end
                MODE_WINDOW:
                begin
                    if (q.running && trig_wr)
                    begin
                        // Early trigger counts as error
                        inc = in_first;
                        dec = ~in_first;
                    end
                    else if (expire)
                        inc = 1'b1;
                end
                MODE_QA:
                begin
                    if ((q.running || start) && ans_wr)
                    begin
                        if (q.acnt == 2'h3)
                        begin
                            // Fourth byte closes the cycle
                            good = !q.abad && match && !in_first;
                            inc = ~good;
                            dec = good;
                        end
                        else
                        begin
                            d.acnt = q.acnt + 2'h1;
                            d.abad = q.abad | ~match | ~in_first;
                        end
                    end
                    else if (expire)
                        inc = 1'b1;
                end
                default: ;
            endcase
            // Every counted event ends the current window
            restart = inc | dec;
        end
        if (restart)
        begin
            d.tick = 24'h000000;
            d.ms = 16'h0000;
            d.acnt = 2'h0;
            d.abad = 1'b0;
        end
        // Question advances only on a good sequence
        if (good)
        begin
            if (q.question == 4'h0)
                d.question = Q_SUBST;
            else
                d.question = {q.question[2:0],
                              q.question[3] ^ q.question[2]};
        end
        // Saturating up/down error counter
        if (inc && q.err != ERR_MAX)
            d.err = q.err + 4'h1;
        else if (dec && q.err != 4'h0)
            d.err = q.err - 4'h1;
        d.irq = (q.err >= thr_level(q.thr)) & ~limp_select;
        d.limp = (q.err >= thr_level(q.thr)) & limp_select & ~sleep_mode;
    end

    always_ff @(posedge clock or negedge rst_n)
    begin
        if (!rst_n)
            q <= '0;
        else
            q <= d;
    end

    // Outputs straight from state flops
    assign sdo = q.tx[7];
    assign sdo_oe = q.cs_sy[1];
    assign irq_out_low = ~q.irq;
    assign inhibit_output = q.limp;

    a_idle_disabled: assert property (@(posedge clock) disable iff (!rst_n)
        !q.en |=> !q.running) else $error("timer runs while disabled");
    a_sleep_stop: assert property (@(posedge clock) disable iff (!rst_n)
        sleep_mode |=> !q.running) else $error("timer runs in sleep");
    a_limp_sleep: assert property (@(posedge clock) disable iff (!rst_n)
        sleep_mode |=> !inhibit_output) else $error("limp on in sleep");
    a_fail_irq: assert property (@(posedge clock) disable iff (!rst_n)
        (q.err >= thr_level(q.thr) && !limp_select) |=> !irq_out_low)
        else $error("failure not flagged on interrupt");
    a_fail_limp: assert property (@(posedge clock) disable iff (!rst_n)
        (q.err >= thr_level(q.thr) && limp_select && !sleep_mode)
        |=> inhibit_output) else $error("limp not driven on failure");
    a_err_step: assert property (@(posedge clock) disable iff (!rst_n)
        (inc && q.err != ERR_MAX) |=> q.err == $past(q.err) + 4'h1)
        else $error("error count did not step up");
    a_err_floor: assert property (@(posedge clock) disable iff (!rst_n)
        (dec && q.err == 4'h0) |=> q.err == 4'h0)
        else $error("error count went below zero");
    a_timing_stop: assert property (@(posedge clock) disable iff (!rst_n)
        timing_wr |=> !q.running ##1 (q.ms == 16'h0000))
        else $error("timer kept running after retiming");
    a_closed_trig: assert property (@(posedge clock) disable iff (!rst_n)
        (q.mode == MODE_WINDOW && q.running && active && trig_wr && in_first
        && q.err != ERR_MAX) |=> q.err == $past(q.err) + 4'h1)
        else $error("closed window trigger not counted");
    a_trig_restart: assert property (@(posedge clock) disable iff (!rst_n)
        (q.mode == MODE_WINDOW && q.running && active && trig_wr)
        |=> (q.ms == 16'h0000 && q.tick == 24'h000000))
        else $error("trigger did not restart window");
    a_keep_question: assert property (@(posedge clock) disable iff (!rst_n)
        (ans_wr && !good) |=> q.question == $past(q.question))
        else $error("question changed on bad answer");
    a_new_question: assert property (@(posedge clock) disable iff (!rst_n)
        good |=> q.question != $past(q.question))
        else $error("no new question after good answer");
    a_zero_subst: assert property (@(posedge clock) disable iff (!rst_n)
        (good && q.question == 4'h0) |=> q.question == Q_SUBST)
        else $error("zero question not replaced");

endmodule
`default_nettype wire

//--- tqw_host.sv
`timescale 1ns/1ps
`default_nettype none
module tqw_host
    import tqw_pkg::*;
(
    input wire logic clock,
    input wire logic sdo,
    input wire logic sdo_oe,
    output logic sclk,
    output logic csn,
    output logic sdi,
    output logic [7:0] rd_data,
    output logic rd_done
);
    // Idle bus: clock low, select high
    initial
    begin
        sclk = 1'b0;
        csn = 1'b1;
        sdi = 1'b0;
        rd_data = 8'h00;
        rd_done = 1'b0;
    end

    // One mode 0 frame; read bits taken just before each rise
    task automatic frame(input logic wr, input logic [6:0] addr,
                         input logic [7:0] data, input int half);
        logic [15:0] word;
        word = {wr, addr, data};
        @(negedge clock);
        csn = 1'b0;
        for (int i = 15; i >= 0; i--)
        begin
            sdi = word[i];
            repeat (half) @(negedge clock);
            // An undriven return line must never pass as data
            if (i < 8)
                rd_data[i] = sdo_oe ? sdo : 1'bx;
            sclk = 1'b1;
            repeat (half) @(negedge clock);
            sclk = 1'b0;
        end
        repeat (half) @(negedge clock);
        csn = 1'b1;
        // Released line flips so no stale level is left behind
        sdi = ~sdi;
        rd_done = !wr;
        repeat (3) @(negedge clock);
        rd_done = 1'b0;
    endtask
endmodule
`default_nettype wire

//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import tqw_pkg::*;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    logic sclk;
    logic csn;
    logic sdi;
    logic sdo;
    logic sdo_oe;
    logic sleep_mode = 1'b0;
    logic standby_mode = 1'b0;
    logic standby_wd_enable = 1'b0;
    logic limp_select = 1'b0;
    logic irq_out_low;
    logic inhibit_output;
    logic [7:0] rd_data;
    logic rd_done;
    logic [15:0] rd_q[$];
    logic [1:0] pin_q[$];
    logic [15:0] note;
    logic [7:0] r;
    int num_errors = 0;
    int checks_done = 0;
    int half = 4;
    event pin_ev;

    // Clock of 100 ns
    always #50 clock = ~clock;

    tqw_watchdog #(.TICK(10)) tqw_watchdog_inst (
        .clock(clock),
        .resetn(resetn),
        .sclk(sclk),
        .csn(csn),
        .sdi(sdi),
        .sdo(sdo),
        .sdo_oe(sdo_oe),
        .sleep_mode(sleep_mode),
        .standby_mode(standby_mode),
        .standby_wd_enable(standby_wd_enable),
        .limp_select(limp_select),
        .irq_out_low(irq_out_low),
        .inhibit_output(inhibit_output)
    );

    tqw_host tqw_host_inst (
        .clock(clock),
        .sdo(sdo),
        .sdo_oe(sdo_oe),
        .sclk(sclk),
        .csn(csn),
        .sdi(sdi),
        .rd_data(rd_data),
        .rd_done(rd_done)
    );

    task automatic bad(input string msg);
        num_errors++;
        $display("BAD %0t %s", $time, msg);
    endtask

    task automatic close_out();
        $display("TB: checks %0d errors %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic do_reset();
        resetn = 1'b0;
        repeat (4) @(negedge clock);
        resetn = 1'b1;
        repeat (6) @(negedge clock);
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        tqw_host_inst.frame(1'b1, a, d, half);
    endtask

    // Expected value and mask noted before the read goes out
    task automatic rd(input logic [6:0] a, input logic [7:0] e,
                      input logic [7:0] m = 8'hff);
        rd_q.push_back({m, e});
        tqw_host_inst.frame(1'b0, a, 8'h00, half);
    endtask

    // Expected {irq_out_low, inhibit_output}
    task automatic pins(input logic [1:0] e);
        repeat (2) @(negedge clock);
        pin_q.push_back(e);
        -> pin_ev;
    endtask

    // Four answer bytes, a question read between; spoil corrupts one
    task automatic qa_run(input logic [3:0] q, input logic [7:0] spoil);
        logic [31:0] a;
        a = ANSWERS[q] ^ {spoil, 24'h000000};
        wr(ADDR_ANSWER, a[31:24]);
        rd(ADDR_QUESTION, {4'h0, q}, 8'h0f);
        wr(ADDR_ANSWER, a[23:16]);
        wr(ADDR_ANSWER, a[15:8]);
        repeat (400) @(negedge clock);
        wr(ADDR_ANSWER, a[7:0]);
    endtask

    // Read results against the oldest note
    always @(posedge rd_done)
    begin
        note = rd_q.pop_front();
        checks_done++;
        if ((rd_data & note[15:8]) !== note[7:0])
            bad("register read differs");
    end

    // Pin levels against the oldest note
    always @(pin_ev)
    begin
        checks_done++;
        if ({irq_out_low, inhibit_output} !== pin_q.pop_front())
            bad("output pins differ");
    end

    // Hang guard, far beyond the expected length
    initial
    begin
        repeat (60000) @(negedge clock);
        bad("run too long");
        close_out();
    end

    initial
    begin
        r = 8'($urandom(32'h1e1ca96d));
        // Reset values and access kinds, slow host
        half = 6;
        do_reset();
        pins(2'b10);
        rd(ADDR_CFG_A, 8'h00);
        rd(ADDR_CFG_B, 8'h00);
        r = 8'($urandom());
        wr(ADDR_RPULSE, r);
        rd(ADDR_RPULSE, r);
        wr(ADDR_QACFG, ~r);
        rd(ADDR_QACFG, ~r);
        rd(7'h40, 8'h00);
        wr(ADDR_QUESTION, 8'hff);
        rd(ADDR_QUESTION, 8'h00);
        for (int m = 0; m < 3; m++)
        begin
            wr(ADDR_CFG_A, {2'(m), 6'h3e});
            rd(ADDR_CFG_A, {2'(m), 6'h32});
        end
        $display("TB: test registers done");
        // Window mode, 128 ms, fifth error fails
        half = 4;
        do_reset();
        wr(ADDR_CFG_A, 8'h41);
        wr(ADDR_CFG_B, 8'h41);
        repeat (1500) @(negedge clock);
        rd(ADDR_CFG_B, 8'h41);
        wr(ADDR_TRIG, 8'h00);
        repeat (700) @(negedge clock);
        wr(ADDR_TRIG, 8'h00);
        rd(ADDR_CFG_B, 8'h41);
        // Each early trigger opens a fresh closed half
        for (int i = 0; i < 4; i++)
            wr(ADDR_TRIG, 8'h00);
        rd(ADDR_CFG_B, 8'h49);
        pins(2'b10);
        wr(ADDR_TRIG, 8'h00);
        rd(ADDR_CFG_B, 8'h4b);
        rd(ADDR_CFG_A, 8'h4d);
        pins(2'b00);
        limp_select = 1'b1;
        pins(2'b11);
        sleep_mode = 1'b1;
        pins(2'b10);
        sleep_mode = 1'b0;
        limp_select = 1'b0;
        $display("TB: test window done");
        // Timeout mode; rewrite halts the timer, 256 ms then
        do_reset();
        wr(ADDR_CFG_A, 8'h00);
        wr(ADDR_CFG_B, 8'h41);
        wr(ADDR_TRIG, 8'h00);
        wr(ADDR_CFG_B, 8'h61);
        repeat (3000) @(negedge clock);
        rd(ADDR_CFG_B, 8'h61);
        wr(ADDR_TRIG, 8'h00);
        repeat (2350) @(negedge clock);
        rd(ADDR_CFG_B, 8'h61);
        repeat (200) @(negedge clock);
        rd(ADDR_CFG_B, 8'h63);
        pins(2'b00);
        wr(ADDR_TRIG, 8'h00);
        rd(ADDR_CFG_B, 8'h61);
        pins(2'b10);
        // Standby without permission stops and clears the timer
        standby_mode = 1'b1;
        repeat (3000) @(negedge clock);
        rd(ADDR_CFG_B, 8'h61);
        standby_mode = 1'b0;
        $display("TB: test expiry done");
        // Question and answer, 128 ms, first error fails
        do_reset();
        wr(ADDR_CFG_A, 8'h80);
        wr(ADDR_CFG_B, 8'h41);
        qa_run(4'h0, 8'h00);
        qa_run(4'h1, 8'h00);
        qa_run(4'h2, 8'h00);
        rd(ADDR_CFG_B, 8'h41);
        pins(2'b10);
        qa_run(4'h4, 8'h5a);
        rd(ADDR_QUESTION, 8'h04, 8'h0f);
        rd(ADDR_CFG_B, 8'h43);
        pins(2'b00);
        $display("TB: test answers done");
        close_out();
    end
endmodule
`default_nettype wire
